/* crs_pkg.sv */
// Purpose: shared constants for the cpu reset sequencer
// Assumes: one bus clock, reset pin sampled on its falling edges
// Notes:   release times are kept in half bus cycles to hold the .5 figures exactly
package crs_pkg;
    // release-to-event times in half bus clock cycles; the low time is in whole cycles
    localparam int CRS_FETCH_HALF = 7;   // first fetch at 3.5 cycles
    localparam int CRS_RISE_HALF  = 23;  // first peripheral clock rise at 11.5 cycles
    localparam int CRS_LOW_MIN    = 4;   // least low cycles before that rise
    localparam int CRS_SYNC_HALF  = 3;   // two falling-edge flops plus the half to a rising edge
    localparam int CRS_FETCH_CYC  = (CRS_FETCH_HALF - CRS_SYNC_HALF) / 2;
    localparam int CRS_RISE_CYC   = (CRS_RISE_HALF - CRS_SYNC_HALF) / 2;
    localparam int CRS_CNT_W      = 4;
    localparam int CRS_DIV_W      = 2;   // half period of the divide-by-eight clock is 4
    localparam int CRS_CTRL_W     = 4;

    typedef enum logic [1:0] {
        CRS_ST_DORMANT = 2'b00,
        CRS_ST_WAIT    = 2'b01,
        CRS_ST_RUN     = 2'b11,
        CRS_ST_GRANT   = 2'b10
    } crs_state_t;
endpackage

/* crs_sync_if.sv */
// Purpose: carries the synchronised run level from the reset synchroniser
// Assumes: run is high only while the reset pin is released
// Notes:   run rises on falling edges of the bus clock and falls at once when the reset pin is asserted
`timescale 1ns/100ps
interface crs_sync_if;
    logic run;
    modport src (output run);
    modport dst (input run);
endinterface

/* crs_reset_sync.sv */
// Purpose: two-stage reset synchroniser on falling bus clock edges
// Assumes: nrst_in may change at any time
// Notes:   assertion is immediate, release takes two falling edges
`timescale 1ns/100ps
module crs_reset_sync
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic clock_in,
    input  wire logic nrst_in,
    // synchronised level
    crs_sync_if.src   sif
);
    typedef struct packed {
        logic s1;
        logic s2;
    } crs_sync_t;

    crs_sync_t sync_r;
    crs_sync_t sync_nxt;

    always_comb
    begin
        sync_nxt    = sync_r;
        sync_nxt.s1 = 1'b1;          // [RULE_10]
        sync_nxt.s2 = sync_r.s1;     // first stage feeds only this flop [RULE_10]
    end

    // falling edge sampling of the released reset [RULE_04]
    always_ff @(negedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sync_r <= '0;
        else
            sync_r <= sync_nxt;
    end

    assign sif.run = sync_r.s2;
endmodule

/* crs_cpu_reset_sequencer.sv */
// Purpose: reset sequencing of a processor core: dormancy, bus float,
//          first fetch timing and peripheral clock resynchronisation
// Assumes: clock_in is the system bus clock; bus request pin is asynchronous
// Notes:   outputs are cleared at once by the reset pin, release is synchronised
//
// Behaviour
// RULE_01 - while reset is held, abort all activity and stay dormant
// RULE_02 - during reset float address and data, drive bus controls inactive
// RULE_03 - peripheral clock goes low on reset, then runs at bus clock over eight
// RULE_04 - reset pin may be asynchronous; sample it on falling bus clock edges
// RULE_05 - reset source holds reset low over five stable clock cycles
// RULE_06 - first instruction fetch comes 3.5 bus cycles after reset release
// RULE_07 - peripheral clock first rises 11.5 cycles after release, low four before
// RULE_08 - bus request active at release grants the bus instead of fetching
// RULE_09 - peripheral clock resynchronisation keeps its timing even when granting
// RULE_10 - reset passes a multi-stage falling-edge synchroniser before use
`timescale 1ns/100ps
module crs_cpu_reset_sequencer
    import crs_pkg::*;
#(
    parameter int CTRL_W = CRS_CTRL_W
)
(
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              nrst_in,
    // bus request from external masters
    input  wire logic              external_bus_request_n_in,
    // peripheral clock
    output logic                   peripheral_clock_out,
    // core sequencing
    output logic                   fetch_start_out,
    output logic                   bus_grant_out,
    // bus drivers
    output logic                   bus_drive_en_out,
    output logic [CTRL_W-1:0]      bus_ctrl_n_out
);
    typedef struct packed {
        crs_state_t                st;
        logic [CRS_CNT_W-1:0]      cnt;
        logic [CRS_DIV_W-1:0]      div;
        logic                      pclk;
        logic                      fetch;
        logic                      grant;
        logic                      drive;
        logic [CTRL_W-1:0]         ctrl_n;
        logic                      req_s1;
        logic                      req_s2;
    } crs_seq_t;

    localparam logic [CRS_CNT_W-1:0] FETCH_AT = CRS_CNT_W'(CRS_FETCH_CYC);
    localparam logic [CRS_CNT_W-1:0] RISE_AT  = CRS_CNT_W'(CRS_RISE_CYC);

    crs_sync_if sif ();
    crs_seq_t   seq_r;
    crs_seq_t   seq_nxt;

    crs_reset_sync u_sync
    (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .sif      (sif)
    );

    always_comb
    begin
        seq_nxt        = seq_r;
        seq_nxt.req_s1 = ~external_bus_request_n_in;
        seq_nxt.req_s2 = seq_r.req_s1;
        seq_nxt.fetch  = 1'b0;
        seq_nxt.ctrl_n = '1;
        if (!sif.run)
        begin
            // everything but the request flops held dormant until release is seen [RULE_01]
            seq_nxt.st    = CRS_ST_DORMANT;
            seq_nxt.cnt   = '0;
            seq_nxt.div   = '0;
            seq_nxt.pclk  = 1'b0;                  // [RULE_03]
            seq_nxt.grant = 1'b0;
            seq_nxt.drive = 1'b0;                  // [RULE_02]
        end
        else
        begin
            // resynchronisation runs the same whatever the bus does [RULE_09]
            if (seq_r.cnt <= RISE_AT)
                seq_nxt.cnt = CRS_CNT_W'(seq_r.cnt + 1'b1);
            if (seq_r.cnt == RISE_AT)
            begin
                seq_nxt.pclk = 1'b1;               // [RULE_07]
                seq_nxt.div  = '0;
            end
            else if (seq_r.cnt > RISE_AT)
            begin
                // divide by eight: toggle every fourth edge [RULE_03]
                seq_nxt.div = CRS_DIV_W'(seq_r.div + 1'b1);
                if (seq_r.div == '1)
                    seq_nxt.pclk = ~seq_r.pclk;
            end

            case (seq_r.st)
                CRS_ST_DORMANT:
                begin
                    // request flops are cleared in reset: first valid sample is one edge later
                    if (seq_r.cnt != '0)
                    begin
                        // request seen at release wins over the fetch [RULE_08]
                        if (seq_r.req_s2)
                        begin
                            seq_nxt.st    = CRS_ST_GRANT;
                            seq_nxt.grant = 1'b1;
                        end
                        else
                            seq_nxt.st = CRS_ST_WAIT;
                    end
                end
                CRS_ST_WAIT:
                begin
                    if (seq_r.cnt == FETCH_AT)
                    begin
                        seq_nxt.st        = CRS_ST_RUN;
                        seq_nxt.fetch     = 1'b1;  // [RULE_06]
                        seq_nxt.drive     = 1'b1;
                        seq_nxt.ctrl_n[0] = 1'b0;
                    end
                end
                CRS_ST_GRANT:
                begin
                    // bus stays floated until the requester lets go [RULE_08]
                    if (!seq_r.req_s2)
                    begin
                        seq_nxt.st        = CRS_ST_RUN;
                        seq_nxt.grant     = 1'b0;
                        seq_nxt.fetch     = 1'b1;
                        seq_nxt.drive     = 1'b1;
                        seq_nxt.ctrl_n[0] = 1'b0;
                    end
                end
                CRS_ST_RUN:
                    seq_nxt.st = CRS_ST_RUN;
                default:
                    seq_nxt.st = CRS_ST_DORMANT;
            endcase
        end
    end

    // pin reset clears at once so no control glitches active [RULE_01] [RULE_02]
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            seq_r        <= '0;
            seq_r.st     <= CRS_ST_DORMANT;
            seq_r.ctrl_n <= '1;
        end
        else
            seq_r <= seq_nxt;
    end

    assign peripheral_clock_out = seq_r.pclk;
    assign fetch_start_out      = seq_r.fetch;
    assign bus_grant_out        = seq_r.grant;
    assign bus_drive_en_out     = seq_r.drive;
    assign bus_ctrl_n_out       = seq_r.ctrl_n;

    // checks
    localparam int RISE_LOW_D = CRS_RISE_CYC + 1 - CRS_LOW_MIN;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_release_free;
        $rose(sif.run) ##1 !seq_r.req_s2;
    endsequence

    sequence s_release_req;
        $rose(sif.run) ##1 seq_r.req_s2;
    endsequence

    sequence s_div8_period;
        peripheral_clock_out [*3] ##1 !peripheral_clock_out [*4] ##1 peripheral_clock_out;
    endsequence

    property p_dormant;
        !sif.run |=> !fetch_start_out && !bus_grant_out;
    endproperty
    a_dormant: assert property (p_dormant) else $error("activity while reset held"); // [RULE_01]

    property p_float;
        !sif.run |=> !bus_drive_en_out && (bus_ctrl_n_out == '1);
    endproperty
    a_float: assert property (p_float) else $error("bus driven during reset"); // [RULE_02]

    property p_pclk_low;
        !sif.run |=> !peripheral_clock_out;
    endproperty
    a_pclk_low: assert property (p_pclk_low) else $error("peripheral clock high in reset"); // [RULE_03]

    property p_div8;
        $rose(peripheral_clock_out) |=> s_div8_period;
    endproperty
    a_div8: assert property (p_div8) else $error("peripheral clock not bus clock over eight"); // [RULE_03]

    property p_fetch;
        s_release_free |-> !fetch_start_out [*2] ##1 fetch_start_out;
    endproperty
    a_fetch: assert property (p_fetch) else $error("first fetch not at 3.5 cycles"); // [RULE_06]

    property p_grant;
        s_release_req |=> bus_grant_out && !fetch_start_out;
    endproperty
    a_grant: assert property (p_grant) else $error("bus not granted at release"); // [RULE_08]

    property p_grant_excl;
        bus_grant_out |-> !fetch_start_out && !bus_drive_en_out;
    endproperty
    a_grant_excl: assert property (p_grant_excl) else $error("fetch while bus granted"); // [RULE_08]

    property p_rise;
        $rose(sif.run) |-> ##RISE_LOW_D !peripheral_clock_out [*4] ##1 peripheral_clock_out;
    endproperty
    a_rise: assert property (p_rise) else $error("peripheral clock rise not at 11.5 cycles"); // [RULE_07] [RULE_09]
endmodule

/* crs_reset_source.sv */
// Purpose: model of the system reset source and an external bus requester
// Assumes: the bench raises its requests on falling clock edges
// Notes:   a short reset request is stretched to the minimum hold
`timescale 1ns/100ps
module crs_reset_source
(
    // clock
    input  wire logic clock_in,
    // requests from the bench
    input  wire logic hold_in,
    input  wire logic bus_req_in,
    // pins toward the device
    output logic      nrst_out,
    output logic      external_bus_request_n_n_out
);
    logic [2:0] held_r = 3'h0;
    logic       rel_r  = 1'b1;
    logic       nrst_r = 1'b1;

    // release only after more than five held cycles, so a glitch cannot half-reset
    always @(negedge clock_in)
    begin
        if (rel_r)
            held_r <= 3'h0;
        else if (held_r != 3'h7)
            held_r <= held_r + 3'h1;
        rel_r <= !hold_in && (rel_r || held_r >= 3'h5);
    end

    // release launched on a rising edge, so it meets setup to the next falling edge
    always @(posedge clock_in)
    begin
        nrst_r <= rel_r && !hold_in;
    end

    assign nrst_out   = nrst_r && !hold_in;
    assign external_bus_request_n_n_out = !bus_req_in;
endmodule

/* crs_cpu_reset_sequencer_tb.sv */
// Purpose: self-checking bench of the cpu reset sequencer
// Assumes: stimulus changes on falling edges, outputs sampled there too
// Notes:   step k counts falling edges after the first one that samples the release
`timescale 1ns/100ps
module crs_cpu_reset_sequencer_tb
    import crs_pkg::*;
;
    logic       clock_in;
    logic       hold;
    logic       bus_req;
    wire logic  nrst_w;
    wire logic  external_bus_request_n_n_w;
    logic       peripheral_clock_out;
    logic       fetch_start_out;
    logic       bus_grant_out;
    logic       bus_drive_en_out;
    logic [3:0] bus_ctrl_n_out;
    int         fail_count = 0;
    int         n_checks   = 0;

    crs_reset_source PARTNER (
        .clock_in   (clock_in),
        .hold_in    (hold),
        .bus_req_in (bus_req),
        .nrst_out   (nrst_w),
        .external_bus_request_n_n_out (external_bus_request_n_n_w)
    );

    crs_cpu_reset_sequencer DUT (
        .clock_in                  (clock_in),
        .nrst_in                   (nrst_w),
        .external_bus_request_n_in (external_bus_request_n_n_w),
        .peripheral_clock_out      (peripheral_clock_out),
        .fetch_start_out           (fetch_start_out),
        .bus_grant_out             (bus_grant_out),
        .bus_drive_en_out          (bus_drive_en_out),
        .bus_ctrl_n_out            (bus_ctrl_n_out)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_idle();
        check({3'h0, peripheral_clock_out}, 4'h0);
        check({3'h0, fetch_start_out}, 4'h0);
        check({3'h0, bus_grant_out}, 4'h0);
        check({3'h0, bus_drive_en_out}, 4'h0);
        check(bus_ctrl_n_out, 4'hf);
    endtask

    // reset in mid-run must clear at once and keep everything dormant
    task automatic t_reset();
        @(negedge clock_in);
        hold <= 1'b1;
        bus_req <= 1'b0;
        #1;
        check_idle();
        repeat (8) @(negedge clock_in);
        check_idle();
    endtask

    // drop_at: request held at release and dropped at that step, 0 for none
    task automatic t_release(input int drop_at, input bit late);
        int k;
        int f_k;
        bus_req <= (drop_at > 0);
        repeat (2) @(negedge clock_in);
        hold <= 1'b0;
        k = 0;
        while (nrst_w !== 1'b1 && k < 12)
        begin
            @(negedge clock_in);
            #1;
            k++;
        end
        if (nrst_w !== 1'b1)
        begin
            fail_count++;
            $display("FAIL t=%0t reset never released", $time);
            summarize();
        end
        f_k = (drop_at > 0) ? drop_at + 3 : 4;
        for (k = 1; k <= 24; k++)
        begin
            @(negedge clock_in);
            check({3'h0, fetch_start_out}, {3'h0, k == f_k});
            check(bus_ctrl_n_out, (k == f_k) ? 4'he : 4'hf);
            check({3'h0, bus_drive_en_out}, {3'h0, k >= f_k});
            check({3'h0, bus_grant_out}, {3'h0, drop_at > 0 && k >= 3 && k < f_k});
            check({3'h0, peripheral_clock_out}, {3'h0, k >= 12 && ((k - 12) / 4) % 2 == 0});
            if (k == drop_at)
                bus_req <= 1'b0;
            if (late && k == 6)
                bus_req <= 1'b1;
            if (late && k == 10)
                bus_req <= 1'b0;
        end
    endtask

    initial
    begin
        // reset falls on the first falling edge so the design sees a clean edge
        hold = 1'b0;
        bus_req = 1'b0;
        @(negedge clock_in);
        hold <= 1'b1;
        repeat (3) @(negedge clock_in);
        check_idle();
        t_release(0, 1'b0);
        t_reset();
        t_release(8, 1'b0);
        t_reset();
        t_release(0, 1'b1);
        t_reset();
        t_release(30, 1'b0);
        t_reset();
        summarize();
    end
endmodule
